// ### fbp_defines.svh
`ifndef FBP_DEFINES_SVH
`define FBP_DEFINES_SVH

// ==========================================================
// Array geometry
// ==========================================================
`define FBP_FLASH_BYTES   65536
`define FBP_ADDR_W        16
`define FBP_WADDR_W       14
`define FBP_DATA_W        32
`define FBP_BLK_LSB       10
`define FBP_REG_LSB       11
`define FBP_NUM_REGIONS   32
`define FBP_REG_IDX_W     5
`define FBP_WORD_IDX_W    8
`define FBP_LAST_WORD     8'hFF

// ==========================================================
// Values
// ==========================================================
`define FBP_ERASED_WORD   32'hFFFFFFFF
`define FBP_ZERO_WORD     32'h00000000

`endif

// ### fbp_eng_if.sv
`timescale 1ns/1ps
`include "fbp_defines.svh"

interface fbp_eng_if;
  logic                      start;
  logic                      erase;
  logic [`FBP_WADDR_W-1:0]   addr;
  logic [`FBP_DATA_W-1:0]    wdata;
  logic                      busy;
  logic                      done;
  logic                      arr_en;
  logic                      arr_we;
  logic [`FBP_WADDR_W-1:0]   arr_addr;
  logic [`FBP_DATA_W-1:0]    arr_wdata;

  modport gate (output start, erase, addr, wdata,
                input  busy, done, arr_en, arr_we, arr_addr, arr_wdata);
  modport eng  (input  start, erase, addr, wdata,
                output busy, done, arr_en, arr_we, arr_addr, arr_wdata);
endinterface

// ### fbp_engine.sv
`timescale 1ns/1ps
`include "fbp_defines.svh"

module fbp_engine
  import fbp_pkg::*;
(
  input  wire logic mclk_i,
  input  wire logic reset_i,
  fbp_eng_if.eng    eng
);

  typedef struct packed {
    fbp_eng_st_t                st;
    logic [`FBP_WORD_IDX_W-1:0] cnt;
    logic [`FBP_WADDR_W-1:0]    addr;
    logic [`FBP_DATA_W-1:0]     wdata;
    logic                       done;
  } fbp_eng_q_t;

  fbp_eng_q_t q;
  fbp_eng_q_t d;

  // ==========================================================
  // Sequencer
  // ==========================================================
  always_comb begin
    d      = q;
    d.done = 1'b0;
    case (q.st)
      FBP_ENG_IDLE: begin
        if (eng.start) begin
          if (eng.erase) begin
            // Whole 1 KB block only, from its first word
            d.st   = FBP_ENG_ERASE;
            d.addr = {eng.addr[`FBP_WADDR_W-1:`FBP_WORD_IDX_W],
                      {`FBP_WORD_IDX_W{1'b0}}};
            d.cnt  = '0;
          end else begin
            d.st    = FBP_ENG_PROG;
            d.addr  = eng.addr;
            d.wdata = eng.wdata;
          end
        end
      end
      FBP_ENG_ERASE: begin
        d.cnt  = q.cnt + 8'h01;
        // Word index stays inside the block, never spills over
        d.addr = {q.addr[`FBP_WADDR_W-1:`FBP_WORD_IDX_W],
                  q.addr[`FBP_WORD_IDX_W-1:0] + 8'h01};
        if (q.cnt == `FBP_LAST_WORD) begin
          d.st   = FBP_ENG_IDLE;
          d.done = 1'b1;
        end
      end
      FBP_ENG_PROG: begin
        d.st   = FBP_ENG_IDLE;
        d.done = 1'b1;
      end
      default: begin
        d.st = FBP_ENG_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      q <= '{st: FBP_ENG_IDLE, cnt: '0, addr: '0, wdata: '0, done: 1'b0};
    end else begin
      q <= d;
    end
  end

  assign eng.busy      = (q.st != FBP_ENG_IDLE);
  assign eng.done      = q.done;
  assign eng.arr_en    = (q.st != FBP_ENG_IDLE);
  assign eng.arr_we    = (q.st != FBP_ENG_IDLE);
  assign eng.arr_addr  = q.addr;
  assign eng.arr_wdata = (q.st == FBP_ENG_ERASE) ? `FBP_ERASED_WORD
                                                 : q.wdata;

endmodule

// ### fbp_flash_model.sv
`timescale 1ns/1ps
// ==========================================================
// Flash array, one-cycle read latency
module fbp_flash_model (
  input  wire logic        mclk_i,
  input  wire logic        en_i,
  input  wire logic        we_i,
  input  wire logic [13:0] addr_i,
  input  wire logic [31:0] wdata_i,
  output logic      [31:0] rdata_o
);
  logic [31:0] mem [16384];
  // Each word starts as its own index so stray writes show up
  initial begin
    for (int i = 0; i < 16384; i++) mem[i] = 32'(i);
    rdata_o = 32'h0;
  end
  // No read this cycle: inverted data, never a stale copy
  always @(posedge mclk_i) begin
    if (en_i && we_i) mem[addr_i] <= wdata_i;
    rdata_o <= (en_i && !we_i) ? mem[addr_i] : ~rdata_o;
  end
endmodule

// ### fbp_gate.sv
`timescale 1ns/1ps
`include "fbp_defines.svh"

// Functional notes
// - The gate decodes the full 64 KB flash range on every access path.
// - Erase acts on one whole 1 KB block, each block erased on its own.
// - After an erase every bit of that block is one and no other block moves.
// - Protection is held per 2 KB region of two blocks, each independent.
// - Each region can be set read-only or execute-only.
// - Erase and program to a read-only region are refused.
// - An execute-only region is readable only by instruction fetch.
// - Data-path and debugger reads of an execute-only region are denied.
module fbp_gate
  import fbp_pkg::*;
(
  input  wire logic                       mclk_i,
  input  wire logic                       reset_i,
  // Instruction fetch
  input  wire logic                       if_req_i,
  input  wire logic [`FBP_ADDR_W-1:0]     if_addr_i,
  output logic                            if_gnt_o,
  output logic                            if_ack_o,
  output logic [`FBP_DATA_W-1:0]          if_rdata_o,
  // Data read, processor or debugger
  input  wire logic                       dr_req_i,
  input  wire logic                       dr_dbg_i,
  input  wire logic [`FBP_ADDR_W-1:0]     dr_addr_i,
  output logic                            dr_gnt_o,
  output logic                            dr_ack_o,
  output logic                            dr_err_o,
  output logic [`FBP_DATA_W-1:0]          dr_rdata_o,
  // Erase / program
  input  wire logic                       pg_req_i,
  input  wire logic                       pg_erase_i,
  input  wire logic [`FBP_ADDR_W-1:0]     pg_addr_i,
  input  wire logic [`FBP_DATA_W-1:0]     pg_wdata_i,
  output logic                            pg_gnt_o,
  output logic                            pg_busy_o,
  output logic                            pg_done_o,
  output logic                            pg_err_o,
  // Protection settings, one bit per region
  input  wire logic [`FBP_NUM_REGIONS-1:0] prot_ro_i,
  input  wire logic [`FBP_NUM_REGIONS-1:0] prot_xo_i,
  // Violation flag
  input  wire logic                       viol_clr_i,
  output logic                            violation_o,
  // Flash array, one-cycle read latency
  output logic                            arr_en_o,
  output logic                            arr_we_o,
  output logic [`FBP_WADDR_W-1:0]         arr_addr_o,
  output logic [`FBP_DATA_W-1:0]          arr_wdata_o,
  input  wire logic [`FBP_DATA_W-1:0]     arr_rdata_i
);

  typedef struct packed {
    fbp_src_t                src;
    logic                    src_err;
    logic                    if_ack;
    logic                    dr_ack;
    logic                    dr_err;
    logic [`FBP_DATA_W-1:0]  rdata;
    logic                    start;
    logic                    erase;
    logic [`FBP_WADDR_W-1:0] addr;
    logic [`FBP_DATA_W-1:0]  wdata;
    logic                    pg_done;
    logic                    pg_err;
    logic                    viol;
  } fbp_gate_q_t;

  fbp_gate_q_t q;
  fbp_gate_q_t d;

  fbp_eng_if eng ();

  fbp_engine u_engine (
    .mclk_i  (mclk_i),
    .reset_i (reset_i),
    .eng     (eng.eng)
  );

  // ==========================================================
  // Per-region protection
  // ==========================================================
  logic [`FBP_NUM_REGIONS-1:0] reg_lock;

  // Either kind of protection freezes the region's contents
  for (genvar r = 0; r < `FBP_NUM_REGIONS; r++) begin : g_lock
    assign reg_lock[r] = prot_ro_i[r] || prot_xo_i[r];
  end

  // ==========================================================
  // Decode and arbitration
  // ==========================================================
  logic                        free;
  logic                        if_take;
  logic                        dr_take;
  logic                        pg_take;
  logic [`FBP_REG_IDX_W-1:0]   dr_reg;
  logic [`FBP_REG_IDX_W-1:0]   pg_reg;
  logic                        dr_deny;
  logic                        pg_deny;

  // Full 16-bit byte address, so all 64 KB decode with no alias
  assign dr_reg  = dr_addr_i[`FBP_ADDR_W-1:`FBP_REG_LSB];
  assign pg_reg  = pg_addr_i[`FBP_ADDR_W-1:`FBP_REG_LSB];

  // Engine owns the array while busy, so reads simply wait
  assign free     = !eng.busy && !q.start;
  assign if_gnt_o = free;
  assign dr_gnt_o = free && !if_req_i;
  assign pg_gnt_o = free && !if_req_i && !dr_req_i;
  assign if_take  = if_req_i && if_gnt_o;
  assign dr_take  = dr_req_i && dr_gnt_o;
  assign pg_take  = pg_req_i && pg_gnt_o;

  // Fetch is never checked: both protections still allow fetch
  // Debugger reads get exactly the data-path answer
  assign dr_deny = prot_xo_i[dr_reg];
  assign pg_deny = reg_lock[pg_reg];

  // ==========================================================
  // State update
  // ==========================================================
  always_comb begin
    d         = q;
    d.if_ack  = 1'b0;
    d.dr_ack  = 1'b0;
    d.dr_err  = 1'b0;
    d.pg_done = eng.done;
    d.pg_err  = 1'b0;
    d.start   = 1'b0;
    d.src     = FBP_SRC_NONE;
    d.src_err = 1'b0;
    // Answer to the read issued last cycle
    case (q.src)
      FBP_SRC_FETCH: begin
        d.if_ack = 1'b1;
        d.rdata  = arr_rdata_i;
      end
      FBP_SRC_DATA: begin
        d.dr_ack = 1'b1;
        d.dr_err = q.src_err;
        // Denied read returns zero, never array data
        d.rdata  = q.src_err ? `FBP_ZERO_WORD : arr_rdata_i;
      end
      default: begin
        d.rdata = q.rdata;
      end
    endcase
    if (if_take) begin
      d.src = FBP_SRC_FETCH;
    end else if (dr_take) begin
      d.src     = FBP_SRC_DATA;
      d.src_err = dr_deny;
    end else if (pg_take) begin
      if (pg_deny) begin
        d.pg_err = 1'b1;
      end else begin
        d.start = 1'b1;
        d.erase = pg_erase_i;
        d.addr  = pg_addr_i[`FBP_ADDR_W-1:2];
        d.wdata = pg_wdata_i;
      end
    end
    // Set wins over clear
    if (viol_clr_i) begin
      d.viol = 1'b0;
    end
    if ((dr_take && !if_take && dr_deny) ||
        (pg_take && !if_take && !dr_take && pg_deny)) begin
      d.viol = 1'b1;
    end
  end

  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      q <= '{src: FBP_SRC_NONE, src_err: 1'b0, if_ack: 1'b0, dr_ack: 1'b0,
             dr_err: 1'b0, rdata: '0, start: 1'b0, erase: 1'b0, addr: '0,
             wdata: '0, pg_done: 1'b0, pg_err: 1'b0, viol: 1'b0};
    end else begin
      q <= d;
    end
  end

  // ==========================================================
  // Engine and array
  // ==========================================================
  assign eng.start = q.start;
  assign eng.erase = q.erase;
  assign eng.addr  = q.addr;
  assign eng.wdata = q.wdata;

  // Denied reads never enable the array
  always_comb begin
    if (eng.busy) begin
      arr_en_o    = eng.arr_en;
      arr_we_o    = eng.arr_we;
      arr_addr_o  = eng.arr_addr;
      arr_wdata_o = eng.arr_wdata;
    end else begin
      arr_en_o    = if_take || (dr_take && !dr_deny);
      arr_we_o    = 1'b0;
      arr_addr_o  = if_take ? if_addr_i[`FBP_ADDR_W-1:2]
                            : dr_addr_i[`FBP_ADDR_W-1:2];
      arr_wdata_o = `FBP_ZERO_WORD;
    end
  end

  assign if_ack_o    = q.if_ack;
  assign if_rdata_o  = q.rdata;
  assign dr_ack_o    = q.dr_ack;
  assign dr_err_o    = q.dr_err;
  assign dr_rdata_o  = q.rdata;
  assign pg_busy_o   = eng.busy || q.start;
  assign pg_done_o   = q.pg_done;
  assign pg_err_o    = q.pg_err;
  assign violation_o = q.viol;

endmodule

// ### fbp_gate_bench.sv
`timescale 1ns/1ps
`include "fbp_defines.svh"
module fbp_gate_bench;
  import fbp_pkg::*;
  typedef struct {logic [15:0] a; logic [31:0] d;} fbp_row_t;
  logic mclk_i = 0, reset_i = 1, viol_clr_i = 0;
  logic if_req_i = 0, dr_req_i = 0, dr_dbg_i = 0, pg_req_i = 0;
  logic pg_erase_i = 0, if_gnt_o, if_ack_o, dr_gnt_o, dr_ack_o, dr_err_o;
  logic pg_gnt_o, pg_busy_o, pg_done_o, pg_err_o, violation_o;
  logic arr_en_o, arr_we_o, err;
  logic [15:0] if_addr_i = 0, dr_addr_i = 0, pg_addr_i = 0;
  logic [31:0] pg_wdata_i = 0, prot_ro_i = 0, prot_xo_i = 0;
  logic [31:0] arr_rdata_i, if_rdata_o, dr_rdata_o, arr_wdata_o, got;
  logic [13:0] arr_addr_o;
  int bad_count = 0, cmp_count = 0;
  fbp_row_t rows [3] = '{'{16'h0000, 32'h1234ABCD},
    '{16'hFFFC, 32'hC0DE0001}, '{16'h8804, 32'h00FF00FF}};
  always #4 mclk_i = ~mclk_i;
  fbp_gate dut (
    .mclk_i(mclk_i), .reset_i(reset_i), .if_req_i(if_req_i),
    .if_addr_i(if_addr_i), .if_gnt_o(if_gnt_o), .if_ack_o(if_ack_o),
    .if_rdata_o(if_rdata_o), .dr_req_i(dr_req_i), .dr_dbg_i(dr_dbg_i),
    .dr_addr_i(dr_addr_i), .dr_gnt_o(dr_gnt_o), .dr_ack_o(dr_ack_o),
    .dr_err_o(dr_err_o), .dr_rdata_o(dr_rdata_o), .pg_req_i(pg_req_i),
    .pg_erase_i(pg_erase_i), .pg_addr_i(pg_addr_i),
    .pg_wdata_i(pg_wdata_i), .pg_gnt_o(pg_gnt_o), .pg_busy_o(pg_busy_o),
    .pg_done_o(pg_done_o), .pg_err_o(pg_err_o), .prot_ro_i(prot_ro_i),
    .prot_xo_i(prot_xo_i), .viol_clr_i(viol_clr_i),
    .violation_o(violation_o), .arr_en_o(arr_en_o), .arr_we_o(arr_we_o),
    .arr_addr_o(arr_addr_o), .arr_wdata_o(arr_wdata_o),
    .arr_rdata_i(arr_rdata_i));
  fbp_flash_model u_flash (.mclk_i(mclk_i), .en_i(arr_en_o),
    .we_i(arr_we_o), .addr_i(arr_addr_o), .wdata_i(arr_wdata_o),
    .rdata_o(arr_rdata_i));
  task automatic complete_run;
    if (bad_count == 0 && cmp_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic chk(string n, logic [31:0] e, logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      bad_count++;
      $display("BAD %s exp %h got %h", n, e, g);
    end
  endtask
  // Read answer arrives a fixed two edges after the take
  task automatic rd(logic f, logic dbg, logic [15:0] a);
    int n;
    @(posedge mclk_i);
    if (f) begin if_req_i <= 1; if_addr_i <= a; end
    else begin dr_req_i <= 1; dr_dbg_i <= dbg; dr_addr_i <= a; end
    for (n = 0; n < 300; n++) begin
      @(negedge mclk_i);
      if ((f ? if_gnt_o : dr_gnt_o) === 1'b1) break;
    end
    if (n == 300) begin bad_count++; complete_run(); end
    @(posedge mclk_i);
    if_req_i <= 0;
    dr_req_i <= 0;
    @(posedge mclk_i);
    @(negedge mclk_i);
    got = f ? if_rdata_o : dr_rdata_o;
    err = dr_err_o;
    chk("ack", 1, f ? if_ack_o : dr_ack_o);
  endtask
  task automatic pg(logic er, logic [15:0] a, logic [31:0] d);
    int n;
    @(posedge mclk_i);
    pg_req_i <= 1; pg_erase_i <= er; pg_addr_i <= a; pg_wdata_i <= d;
    for (n = 0; n < 300; n++) begin
      @(negedge mclk_i);
      if (pg_gnt_o === 1'b1) break;
    end
    if (n == 300) begin bad_count++; complete_run(); end
    @(posedge mclk_i);
    pg_req_i <= 0;
    for (n = 0; n < 300; n++) begin
      @(negedge mclk_i);
      if (pg_done_o === 1'b1 || pg_err_o === 1'b1) break;
    end
    if (n == 300) begin bad_count++; complete_run(); end
    err = pg_err_o;
    chk("pg_idle", 0, pg_busy_o);
  endtask
  initial begin
    repeat (3) @(posedge mclk_i);
    reset_i <= 0;
    @(negedge mclk_i);
    chk("viol_rst", 0, violation_o);
    foreach (rows[i]) begin
      pg(0, rows[i].a, rows[i].d);
      chk("pg_err", 0, err);
      rd(1, 0, rows[i].a);
      chk("fetch", rows[i].d, got);
      rd(0, 0, rows[i].a);
      chk("data", rows[i].d, got);
    end
    @(posedge mclk_i);
    prot_ro_i <= 32'h2;
    pg(0, 16'h0810, 32'h5A5A5A5A);
    chk("ro_pg", 1, err);
    chk("ro_viol", 1, violation_o);
    pg(1, 16'h0C00, 32'h0);
    chk("ro_er", 1, err);
    rd(0, 0, 16'h0810);
    chk("ro_keep", 32'h204, got);
    rd(0, 0, 16'h0C00);
    chk("ro_keep2", 32'h300, got);
    @(posedge mclk_i);
    viol_clr_i <= 1;
    @(posedge mclk_i);
    viol_clr_i <= 0;
    prot_xo_i  <= 32'h4;
    @(negedge mclk_i);
    chk("viol_clr", 0, violation_o);
    // First denied read lands while clear is held: set must win
    for (int k = 0; k < 2; k++) begin
      @(posedge mclk_i);
      viol_clr_i <= (k == 0);
      rd(0, k[0], 16'h1004);
      chk("xo_err", 1, err);
      chk("xo_data", 0, got);
    end
    chk("xo_viol", 1, violation_o);
    rd(1, 0, 16'h1004);
    chk("xo_fetch", 32'h401, got);
    pg(0, 16'h1004, 32'h0);
    chk("xo_pg", 1, err);
    rd(0, 0, 16'h1804);
    chk("indep", 32'h601, got);
    pg(1, 16'h2678, 32'h0);
    chk("er_err", 0, err);
    foreach (rows[i]) begin
      rd(0, 0, 16'h2400 + 16'(i) * 16'h01FE);
      chk("erased", 32'hFFFFFFFF, got);
    end
    rd(0, 0, 16'h23FC);
    chk("below", 32'h8FF, got);
    rd(0, 0, 16'h2800);
    chk("above", 32'hA00, got);
    // Mid-run reset: flag and engine clear, array keeps its contents
    @(posedge mclk_i);
    reset_i <= 1;
    repeat (2) @(posedge mclk_i);
    reset_i <= 0;
    @(negedge mclk_i);
    chk("rst_viol", 0, violation_o);
    chk("rst_busy", 0, pg_busy_o);
    rd(0, 0, 16'h0000);
    chk("rst_keep", 32'h1234ABCD, got);
    complete_run();
  end
endmodule

// ### fbp_gate_properties.sv
`timescale 1ns/1ps
// ==========================================================
// Port checks for the flash gate
module fbp_gate_properties (
  input wire logic        mclk_i,
  input wire logic        reset_i,
  input wire logic        if_req_i,
  input wire logic        if_gnt_o,
  input wire logic        if_ack_o,
  input wire logic        dr_req_i,
  input wire logic        dr_gnt_o,
  input wire logic [15:0] dr_addr_i,
  input wire logic        dr_ack_o,
  input wire logic        dr_err_o,
  input wire logic [31:0] dr_rdata_o,
  input wire logic        pg_req_i,
  input wire logic        pg_gnt_o,
  input wire logic        pg_erase_i,
  input wire logic [15:0] pg_addr_i,
  input wire logic [31:0] pg_wdata_i,
  input wire logic        pg_busy_o,
  input wire logic        pg_done_o,
  input wire logic        pg_err_o,
  input wire logic [31:0] prot_ro_i,
  input wire logic [31:0] prot_xo_i,
  input wire logic        violation_o,
  input wire logic        arr_en_o,
  input wire logic        arr_we_o,
  input wire logic [13:0] arr_addr_o,
  input wire logic [31:0] arr_wdata_o
);
  logic dr_tk, dr_xo, pg_tk, pg_bad;
  logic [13:0] pg_wa;
  logic [5:0] pg_blk;
  assign dr_tk = dr_req_i && dr_gnt_o;
  assign dr_xo = prot_xo_i[dr_addr_i[15:11]];
  assign pg_tk = pg_req_i && pg_gnt_o;
  assign pg_bad = prot_ro_i[pg_addr_i[15:11]] | prot_xo_i[pg_addr_i[15:11]];
  assign pg_wa = pg_addr_i[15:2];
  assign pg_blk = pg_addr_i[15:10];
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (reset_i);
  sequence s_wipe;
    arr_we_o && arr_wdata_o == 32'hFFFFFFFF
      && arr_addr_o == {$past(pg_blk, 2), 8'h00};
  endsequence
  sequence s_write;
    arr_we_o && arr_addr_o == $past(pg_wa, 2)
      && arr_wdata_o == $past(pg_wdata_i, 2);
  endsequence
  property p_fetch;
    if_req_i && if_gnt_o |-> ##2 if_ack_o && !dr_ack_o;
  endproperty
  property p_dr_deny;
    dr_tk && dr_xo |-> !arr_en_o ##1 violation_o
      ##1 (dr_ack_o && dr_err_o && dr_rdata_o == 32'h0);
  endproperty
  property p_dr_ok;
    dr_tk && !dr_xo |-> ##2 dr_ack_o && !dr_err_o;
  endproperty
  property p_dr_addr;
    dr_tk && !dr_xo |-> arr_en_o && !arr_we_o
      && arr_addr_o == dr_addr_i[15:2];
  endproperty
  property p_pg_ref;
    pg_tk && pg_bad |-> ##1 (pg_err_o ##0 (!arr_we_o [*3]));
  endproperty
  property p_prog;
    pg_tk && !pg_bad && !pg_erase_i |-> ##2 s_write ##2 pg_done_o;
  endproperty
  property p_erase;
    pg_tk && !pg_bad && pg_erase_i |-> ##2 s_wipe ##257 pg_done_o;
  endproperty
  property p_busy;
    pg_tk && !pg_bad |=> pg_busy_o;
  endproperty
  property p_hold;
    pg_busy_o |-> !if_gnt_o && !dr_gnt_o && !pg_gnt_o;
  endproperty
  property p_viol_set;
    pg_err_o |-> violation_o;
  endproperty
  a_fetch: assert property (p_fetch) else $error("fetch ack");
  a_dr_deny: assert property (p_dr_deny) else $error("xo read");
  a_dr_ok: assert property (p_dr_ok) else $error("data read");
  a_dr_addr: assert property (p_dr_addr) else $error("rd addr");
  a_pg_ref: assert property (p_pg_ref) else $error("refuse");
  a_prog: assert property (p_prog) else $error("program");
  a_erase: assert property (p_erase) else $error("erase");
  a_viol_set: assert property (p_viol_set) else $error("flag");
  a_busy: assert property (p_busy) else $error("busy");
  a_hold: assert property (p_hold) else $error("grant in busy");
endmodule
bind fbp_gate fbp_gate_properties u_props (
  .mclk_i(mclk_i), .reset_i(reset_i), .if_req_i(if_req_i),
  .if_gnt_o(if_gnt_o), .if_ack_o(if_ack_o), .dr_req_i(dr_req_i),
  .dr_gnt_o(dr_gnt_o), .dr_addr_i(dr_addr_i), .dr_ack_o(dr_ack_o),
  .dr_err_o(dr_err_o), .dr_rdata_o(dr_rdata_o), .pg_req_i(pg_req_i),
  .pg_gnt_o(pg_gnt_o), .pg_erase_i(pg_erase_i), .pg_addr_i(pg_addr_i),
  .pg_wdata_i(pg_wdata_i), .pg_busy_o(pg_busy_o), .pg_done_o(pg_done_o),
  .pg_err_o(pg_err_o), .prot_ro_i(prot_ro_i), .prot_xo_i(prot_xo_i),
  .violation_o(violation_o), .arr_en_o(arr_en_o), .arr_we_o(arr_we_o),
  .arr_addr_o(arr_addr_o), .arr_wdata_o(arr_wdata_o));

// ### fbp_pkg.sv
package fbp_pkg;
  typedef enum logic [1:0] {
    FBP_SRC_NONE,
    FBP_SRC_FETCH,
    FBP_SRC_DATA
  } fbp_src_t;

  typedef enum logic [1:0] {
    FBP_ENG_IDLE,
    FBP_ENG_ERASE,
    FBP_ENG_PROG
  } fbp_eng_st_t;
endpackage
